/* File: rtl/cwb_pkg.sv */
package cwb_pkg;

  // ==========================================================
  // Geometry
  localparam int HALVES    = 2;
  localparam int LINE_LSB  = 4;
  localparam int LINE_W    = 32 - LINE_LSB;
  localparam int WORDS     = 4;
  localparam int LANES     = 4;
  localparam int HALF_BITS = WORDS * LANES * 8;
  localparam int HALF_BE   = WORDS * LANES;

  localparam logic [3:0] BE_NONE = 4'h0;
  localparam logic [3:0] BE_WORD = 4'hf;
  localparam logic [1:0] BE_HALF = 2'h3;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    CWB_STORE   = 2'b00,
    CWB_LOAD    = 2'b01,
    CWB_BARRIER = 2'b10
  } cwb_kind_t;

  typedef struct packed {
    cwb_kind_t   kind;
    logic        uncached;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cwb_core_req_t;

  typedef struct packed {
    logic        write;
    logic        last;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cwb_bus_req_t;

  typedef enum logic [1:0] {
    DR_IDLE = 2'b00,
    DR_SEND = 2'b01,
    DR_WAIT = 2'b10,
    DR_READ = 2'b11
  } cwb_drain_t;

endpackage

/* File: rtl/cwb_port.sv */
`timescale 1ns/1ps
module cwb_port (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic                   merge_full,
  input  wire logic                   aligned_lane_mode,
  input  wire logic                   core_req_valid,
  input  wire cwb_pkg::cwb_core_req_t core_req,
  output logic                        core_ack,
  output logic                        core_stall,
  output logic [31:0]                 core_rdata,
  output logic                        bus_valid,
  output cwb_pkg::cwb_bus_req_t       bus_req,
  input  wire logic                   bus_ready,
  input  wire logic                   bus_write_done,
  input  wire logic                   bus_read_done,
  input  wire logic [31:0]            bus_rdata
);

  // ==========================================================
  // Helpers

  // Naturally aligned byte, halfword or word.
  function automatic logic legal_be(input logic [3:0] be);
    case (be)
      4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf: legal_be = 1'b1;
      default: legal_be = 1'b0;
    endcase
  endfunction

  function automatic logic tri_be(input logic [3:0] be);
    tri_be = (be == 4'h7) || (be == 4'he);
  endfunction

  // Lowest word of the line that still has bytes to send.
  function automatic logic [1:0] first_word(input logic [15:0] be);
    first_word = 2'h0;
    for (int w = cwb_pkg::WORDS - 1; w >= 0; w--) begin
      if (be[w*4 +: 4] != cwb_pkg::BE_NONE) begin
        first_word = 2'(w);
      end
    end
  endfunction

  // ==========================================================
  // Mode straps

  // Straps are pins, so they pass two flip-flops before use.
  logic [1:0] mf_sync_r;
  logic [1:0] al_sync_r;
  logic       merge_full_r;
  logic       aligned_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mf_sync_r <= 2'b00;
      al_sync_r <= 2'b00;
    end else begin
      mf_sync_r <= {mf_sync_r[0], merge_full};
      al_sync_r <= {al_sync_r[0], aligned_lane_mode};
    end
  end

  assign merge_full_r = mf_sync_r[1];
  assign aligned_r    = al_sync_r[1];

  // ==========================================================
  // State

  logic [127:0]            buf_data_r [cwb_pkg::HALVES];
  logic [127:0]            buf_data_nxt [cwb_pkg::HALVES];
  logic [15:0]             buf_be_r [cwb_pkg::HALVES];
  logic [15:0]             buf_be_nxt [cwb_pkg::HALVES];
  logic [cwb_pkg::LINE_W-1:0] buf_line_r [cwb_pkg::HALVES];
  logic [cwb_pkg::LINE_W-1:0] buf_line_nxt [cwb_pkg::HALVES];
  logic                    coll_sel_r;
  logic                    coll_sel_nxt;
  logic                    coll_valid_r;
  logic                    coll_valid_nxt;
  logic                    coll_unc_r;
  logic                    coll_unc_nxt;
  logic                    rd_pend_r;
  logic                    rd_pend_nxt;
  logic                    core_ack_r;
  logic                    core_ack_nxt;
  logic                    core_stall_r;
  logic                    core_stall_nxt;
  cwb_pkg::cwb_drain_t     dr_r;
  cwb_pkg::cwb_drain_t     dr_nxt;
  logic [15:0]             rem_r;
  logic [15:0]             rem_nxt;
  logic                    bus_valid_r;
  logic                    bus_valid_nxt;
  cwb_pkg::cwb_bus_req_t   bus_req_r;
  cwb_pkg::cwb_bus_req_t   bus_req_nxt;
  logic [31:0]             core_rdata_r;
  logic [31:0]             core_rdata_nxt;
  logic                    rd_done_r;
  logic                    rd_done_nxt;

  // Decode of the pending core request.
  logic [cwb_pkg::LINE_W-1:0] req_line;
  logic [1:0]              req_word;
  logic                    line_hit;
  logic                    word_used;
  logic                    live;
  logic                    need_move;
  logic                    go;
  logic                    move;
  logic                    rd_start;
  logic                    is_store;
  logic                    is_load;

  assign req_line  = core_req.addr[31:cwb_pkg::LINE_LSB];
  assign req_word  = core_req.addr[3:2];
  assign is_store  = core_req.kind == cwb_pkg::CWB_STORE;
  assign is_load   = core_req.kind == cwb_pkg::CWB_LOAD;
  assign line_hit  = coll_valid_r && (buf_line_r[coll_sel_r] == req_line);
  assign word_used = buf_be_r[coll_sel_r][{req_word, 2'b00} +: 4] != cwb_pkg::BE_NONE;
  // A request is live until acked, but not while an uncached read is pending; the ack cycle itself is masked.
  assign live      = core_req_valid && !core_ack_r && !rd_pend_r;

  // Any reason to push the collecting half out before serving.
  always_comb begin
    need_move = 1'b0;
    if (coll_valid_r) begin
      need_move = coll_unc_r || core_req.uncached
               || (core_req.kind == cwb_pkg::CWB_BARRIER)
               || (is_load && line_hit)
               || (is_store && !line_hit)
               || (is_store && !merge_full_r && word_used);
    end
  end

  // The swap only happens once the drain half is free.
  assign move     = coll_valid_r && (dr_r == cwb_pkg::DR_IDLE)
                 && (coll_unc_r || (live && need_move));
  assign go       = live && !need_move;
  assign rd_start = go && is_load && core_req.uncached && (dr_r == cwb_pkg::DR_IDLE);

  // ==========================================================
  // Collecting half and core handshake

  // Stores write lane by lane; newer bytes win, enables accumulate.
  always_comb begin
    buf_data_nxt   = buf_data_r;
    buf_be_nxt     = buf_be_r;
    buf_line_nxt   = buf_line_r;
    coll_sel_nxt   = coll_sel_r;
    coll_valid_nxt = coll_valid_r;
    coll_unc_nxt   = coll_unc_r;
    rd_pend_nxt    = rd_pend_r;
    core_ack_nxt   = 1'b0;
    if (move) begin
      coll_sel_nxt   = !coll_sel_r;
      coll_valid_nxt = 1'b0;
      coll_unc_nxt   = 1'b0;
    end else if (go) begin
      case (core_req.kind)
        cwb_pkg::CWB_STORE: begin
          if (!coll_valid_r) begin
            buf_line_nxt[coll_sel_r] = req_line;
            buf_be_nxt[coll_sel_r]   = '0;
          end
          for (int i = 0; i < cwb_pkg::LANES; i++) begin
            if (core_req.be[i]) begin
              buf_data_nxt[coll_sel_r][{req_word, 5'(i*8)} +: 8] =
                core_req.wdata[i*8 +: 8];
            end
          end
          buf_be_nxt[coll_sel_r][{req_word, 2'b00} +: 4] =
            (coll_valid_r ? buf_be_r[coll_sel_r][{req_word, 2'b00} +: 4] : 4'h0)
            | core_req.be;
          coll_valid_nxt = 1'b1;
          coll_unc_nxt   = core_req.uncached;
          core_ack_nxt   = 1'b1;
        end
        cwb_pkg::CWB_LOAD: begin
          if (!core_req.uncached) begin
            core_ack_nxt = 1'b1;
          end else if (rd_start) begin
            rd_pend_nxt = 1'b1;
          end
        end
        default: begin
          core_ack_nxt = 1'b1;
        end
      endcase
    end
    if (rd_done_r) begin
      rd_pend_nxt  = 1'b0;
      core_ack_nxt = 1'b1;
    end
    core_stall_nxt = core_req_valid && !core_ack_nxt && !core_ack_r;
  end

  // Data is cleared at reset only, so disabled lanes of a partial line can still carry older bytes.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int h = 0; h < cwb_pkg::HALVES; h++) begin
        buf_data_r[h] <= '0;
        buf_be_r[h]   <= '0;
        buf_line_r[h] <= '0;
      end
      coll_sel_r   <= 1'b0;
      coll_valid_r <= 1'b0;
      coll_unc_r   <= 1'b0;
      rd_pend_r    <= 1'b0;
      core_ack_r   <= 1'b0;
      core_stall_r <= 1'b0;
    end else begin
      buf_data_r   <= buf_data_nxt;
      buf_be_r     <= buf_be_nxt;
      buf_line_r   <= buf_line_nxt;
      coll_sel_r   <= coll_sel_nxt;
      coll_valid_r <= coll_valid_nxt;
      coll_unc_r   <= coll_unc_nxt;
      rd_pend_r    <= rd_pend_nxt;
      core_ack_r   <= core_ack_nxt;
      core_stall_r <= core_stall_nxt;
    end
  end

  // ==========================================================
  // Drain half and bus side

  // Beats peel enable bits off rem_r; in aligned lane mode an illegal word sends its low
  // pair first and the high pair on the next beat.
  always_comb begin
    logic [1:0] w;
    logic [3:0] wb;
    logic [3:0] pb;
    w              = first_word(rem_r);
    wb             = rem_r[{w, 2'b00} +: 4];
    pb             = wb;
    dr_nxt         = dr_r;
    rem_nxt        = rem_r;
    bus_req_nxt    = bus_req_r;
    bus_valid_nxt  = bus_valid_r && !bus_ready;
    core_rdata_nxt = core_rdata_r;
    rd_done_nxt    = 1'b0;
    if (aligned_r && !legal_be(wb)) begin
      pb = {2'b00, wb[1:0] & cwb_pkg::BE_HALF};
    end
    case (dr_r)
      cwb_pkg::DR_IDLE: begin
        if (move) begin
          rem_nxt = buf_be_r[coll_sel_r];
          dr_nxt  = cwb_pkg::DR_SEND;
        end else if (rd_start) begin
          bus_req_nxt.write = 1'b0;
          bus_req_nxt.last  = 1'b1;
          bus_req_nxt.addr  = {core_req.addr[31:2], 2'b00};
          bus_req_nxt.be    = (aligned_r && tri_be(core_req.be))
                              ? cwb_pkg::BE_WORD : core_req.be;
          bus_req_nxt.wdata = '0;
          bus_valid_nxt     = 1'b1;
          dr_nxt            = cwb_pkg::DR_READ;
        end
      end
      cwb_pkg::DR_SEND: begin
        if (!bus_valid_r || bus_ready) begin
          if (rem_r != '0) begin
            rem_nxt[{w, 2'b00} +: 4] = wb & ~pb;
            bus_req_nxt.write = 1'b1;
            bus_req_nxt.addr  = {buf_line_r[!coll_sel_r], w, 2'b00};
            bus_req_nxt.be    = pb;
            bus_req_nxt.wdata = buf_data_r[!coll_sel_r][{w, 5'h00} +: 32];
            bus_req_nxt.last  = rem_nxt == '0;
            bus_valid_nxt     = 1'b1;
          end else begin
            dr_nxt = cwb_pkg::DR_WAIT;
          end
        end
      end
      cwb_pkg::DR_WAIT: begin
        if (bus_write_done) begin
          dr_nxt = cwb_pkg::DR_IDLE;
        end
      end
      cwb_pkg::DR_READ: begin
        if (!bus_valid_r && bus_read_done) begin
          core_rdata_nxt = bus_rdata;
          rd_done_nxt    = 1'b1;
          dr_nxt         = cwb_pkg::DR_IDLE;
        end
      end
      default: begin
        dr_nxt = cwb_pkg::DR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dr_r         <= cwb_pkg::DR_IDLE;
      rem_r        <= '0;
      bus_valid_r  <= 1'b0;
      bus_req_r    <= '0;
      core_rdata_r <= '0;
      rd_done_r    <= 1'b0;
    end else begin
      dr_r         <= dr_nxt;
      rem_r        <= rem_nxt;
      bus_valid_r  <= bus_valid_nxt;
      bus_req_r    <= bus_req_nxt;
      core_rdata_r <= core_rdata_nxt;
      rd_done_r    <= rd_done_nxt;
    end
  end

  // Outputs come straight from flip-flops.
  assign core_ack   = core_ack_r;
  assign core_stall = core_stall_r;
  assign core_rdata = core_rdata_r;
  assign bus_valid  = bus_valid_r;
  assign bus_req    = bus_req_r;

  // ==========================================================
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_lane_legal: assert property (
    bus_valid_r && bus_req_r.write && aligned_r && $past(aligned_r, 2)
    |-> legal_be(bus_req_r.be)) else $error("illegal lane enables");

  a_move_swap: assert property (
    move |=> (coll_sel_r != $past(coll_sel_r)) && (dr_r == cwb_pkg::DR_SEND)
    ) else $error("move did not swap halves");

  a_drain_hold: assert property (
    (dr_r == cwb_pkg::DR_WAIT) && !bus_write_done
    |=> (dr_r == cwb_pkg::DR_WAIT) && !$past(move)) else $error("drain freed early");

  a_one_line: assert property (
    go && is_store && coll_valid_r |-> line_hit) else $error("two lines in half");

  a_nomerge_word: assert property (
    go && is_store && coll_valid_r && !merge_full_r |-> !word_used
    ) else $error("word merged in no-merge");

  a_load_hit: assert property (
    live && is_load && line_hit |-> !go ##1 !core_ack_r) else $error("load passed line");

  a_unc_first: assert property (
    rd_start |-> !coll_valid_r) else $error("uncached read before move");

  a_tri_word: assert property (
    rd_start && aligned_r && tri_be(core_req.be)
    |=> bus_valid_r && (bus_req_r.be == cwb_pkg::BE_WORD)) else $error("tri-byte read");

  a_union_be: assert property (
    go && is_store && line_hit
    |=> (buf_be_r[coll_sel_r] | $past(buf_be_r[coll_sel_r])) == buf_be_r[coll_sel_r]
    ) else $error("enables lost");

  a_barrier: assert property (
    go && (core_req.kind == cwb_pkg::CWB_BARRIER) |-> !coll_valid_r
    ) else $error("barrier left data");

  c_move: cover property (move ##1 (dr_r == cwb_pkg::DR_SEND));
  c_split: cover property (bus_valid_r && bus_ready && !legal_be(rem_r[3:0]) && aligned_r);
  c_read: cover property (rd_start ##[1:20] rd_done_r);
  c_stall: cover property (core_stall_r [*3] ##1 core_ack_r);

endmodule

/* File: tb/cwb_bus_partner.sv */
`timescale 1ns/1ps
// ==========================================================
// Bus party model: takes beats, then answers writes and reads after a delay.
module cwb_bus_partner #(
  parameter logic [31:0] SEED = 32'h1f2e3d4c
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  slow,
  input  wire logic                  bus_valid,
  input  wire cwb_pkg::cwb_bus_req_t bus_req,
  output logic                       bus_ready,
  output logic                       bus_write_done,
  output logic                       bus_read_done,
  output logic [31:0]                bus_rdata
);
  logic [31:0] st   = SEED;
  logic        tk_w = 1'b0;
  logic        tk_r = 1'b0;
  logic [31:0] tk_a = '0;
  logic [31:0] rd_a = '0;
  int          wr_cnt = 0;
  int          rd_cnt = 0;

  // Outputs start quiet so the design never sees an unknown answer.
  initial begin
    bus_ready      = 1'b0;
    bus_write_done = 1'b0;
    bus_read_done  = 1'b0;
    bus_rdata      = 32'h0;
  end

  // Note which kind of beat was taken at each rising edge.
  always @(posedge clk_sys) begin
    tk_w <= !reset && bus_valid && bus_ready && bus_req.write && bus_req.last;
    tk_r <= !reset && bus_valid && bus_ready && !bus_req.write;
    tk_a <= bus_req.addr;
  end

  // Answer on the falling edge; idle read data toggles so stale data is never mistaken.
  always @(negedge clk_sys) begin
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    if (reset) begin
      wr_cnt = 0;
      rd_cnt = 0;
    end
    if (tk_w) wr_cnt = slow ? int'(st[3:2]) + 1 : 1;
    if (tk_r) begin
      rd_cnt = slow ? int'(st[5:4]) + 1 : 1;
      rd_a   = tk_a;
    end
    bus_ready      <= !reset && (!slow || st[0]);
    bus_write_done <= (wr_cnt == 1);
    bus_read_done  <= (rd_cnt == 1);
    bus_rdata      <= (rd_cnt == 1) ? (rd_a ^ 32'h5a5ac3c3) : ~bus_rdata;
    if (wr_cnt > 0) wr_cnt--;
    if (rd_cnt > 0) rd_cnt--;
  end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
// ==========================================================
// Bench: random core traffic checked beat by beat against a queue model.
module tb_top;
  logic                   clk_sys;
  logic                   reset;
  logic                   merge_full;
  logic                   aligned_lane_mode;
  logic                   slow;
  logic                   core_req_valid;
  cwb_pkg::cwb_core_req_t core_req;
  logic                   core_ack;
  logic                   core_stall;
  logic [31:0]            core_rdata;
  logic                   bus_valid;
  cwb_pkg::cwb_bus_req_t  bus_req;
  logic                   bus_ready;
  logic                   bus_write_done;
  logic                   bus_read_done;
  logic [31:0]            bus_rdata;
  int                     mismatches = 0;
  int                     num_checks = 0;
  logic [31:0]            seed = 32'h8aa3;
  logic [7:0]             cb [16];
  logic [15:0]            cbe = '0;
  logic [27:0]            cline = '0;
  logic                   mf = 1'b0;
  logic                   al = 1'b0;
  logic                   burst_open = 1'b0;
  cwb_pkg::cwb_bus_req_t  e;
  cwb_pkg::cwb_bus_req_t  exp_q [$];
  logic [3:0]             pats [9] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'h7, 4'he, 4'hf};

  cwb_port cwb_port_inst (.clk_sys(clk_sys), .reset(reset), .merge_full(merge_full),
    .aligned_lane_mode(aligned_lane_mode), .core_req_valid(core_req_valid),
    .core_req(core_req), .core_ack(core_ack), .core_stall(core_stall),
    .core_rdata(core_rdata), .bus_valid(bus_valid), .bus_req(bus_req),
    .bus_ready(bus_ready), .bus_write_done(bus_write_done),
    .bus_read_done(bus_read_done), .bus_rdata(bus_rdata));

  cwb_bus_partner cwb_bus_partner_inst (.clk_sys(clk_sys), .reset(reset), .slow(slow),
    .bus_valid(bus_valid), .bus_req(bus_req), .bus_ready(bus_ready),
    .bus_write_done(bus_write_done), .bus_read_done(bus_read_done), .bus_rdata(bus_rdata));

  // ==========================================================
  // Clock at 250 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Checking and closing.
  task automatic check(input logic [69:0] seen, input logic [69:0] expv);
    num_checks++;
    if (seen !== expv) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Only enabled byte lanes carry meaning on a write beat.
  function automatic logic [31:0] lmask(input cwb_pkg::cwb_bus_req_t b);
    return b.write ? {{8{b.be[3]}}, {8{b.be[2]}}, {8{b.be[1]}}, {8{b.be[0]}}} : 32'h0;
  endfunction

  // ==========================================================
  // Model: expected beats are queued in the order the drain must send them.
  task automatic push_word(input logic [31:0] a, input logic [3:0] be, input logic [31:0] d,
                           input logic wr);
    cwb_pkg::cwb_bus_req_t b;
    b = '{wr, 1'b0, a, be, d};
    if (al && wr && !(be inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf})) begin
      b.be = be & 4'h3;
      exp_q.push_back(b);
      b.be = be & 4'hc;
    end
    exp_q.push_back(b);
  endtask

  task automatic flush();
    int n0;
    logic [31:0] d;
    n0 = exp_q.size();
    for (int w = 0; w < 4; w++) begin
      if (cbe[4*w +: 4] != 4'h0) begin
        d = {cb[4*w+3], cb[4*w+2], cb[4*w+1], cb[4*w]};
        push_word({cline, w[1:0], 2'b00}, cbe[4*w +: 4], d, 1'b1);
      end
    end
    if (exp_q.size() > n0) exp_q[exp_q.size()-1].last = 1'b1;
    cbe = '0;
  endtask

  task automatic model(input cwb_pkg::cwb_kind_t k, input logic unc, input logic [31:0] a,
                       input logic [3:0] be, input logic [31:0] d);
    if (k == cwb_pkg::CWB_BARRIER || unc || (k == cwb_pkg::CWB_LOAD && a[31:4] == cline)) begin
      flush();
    end
    if (k == cwb_pkg::CWB_STORE) begin
      if (a[31:4] != cline || (!mf && cbe[{a[3:2], 2'b00} +: 4] != 4'h0)) flush();
      cline = a[31:4];
      for (int i = 0; i < 4; i++) begin
        if (be[i]) begin
          cb[{a[3:2], i[1:0]}]  = d[8*i +: 8];
          cbe[{a[3:2], i[1:0]}] = 1'b1;
        end
      end
      if (unc) flush();
    end else if (k == cwb_pkg::CWB_LOAD && unc) begin
      push_word({a[31:2], 2'b00}, (al && (be == 4'h7 || be == 4'he)) ? 4'hf : be, 32'h0, 1'b0);
      exp_q[exp_q.size()-1].last = 1'b1;
    end
  endtask

  // One core request, held until acknowledged.
  task automatic core_op(input cwb_pkg::cwb_kind_t k, input logic unc, input logic [31:0] a,
                         input logic [3:0] be, input logic [31:0] d);
    int n;
    model(k, unc, a, be, d);
    core_req       = '{k, unc, a, be, d};
    core_req_valid = 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 1) check({69'h0, core_stall}, {69'h0, core_ack !== 1'b1});
    end while (core_ack !== 1'b1 && n < 3000);
    check({69'h0, core_ack}, 70'h1);
    if (k == cwb_pkg::CWB_LOAD && unc) begin
      check({38'h0, core_rdata}, {38'h0, {a[31:2], 2'b00} ^ 32'h5a5ac3c3});
    end
    @(negedge clk_sys);
    core_req_valid = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic drain_wait();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || burst_open) && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    check({69'h0, exp_q.size() != 0 || burst_open}, 70'h0);
  endtask

  // ==========================================================
  // Compare every taken beat with the model; a new write burst may not start
  // before the previous one is reported complete.
  always @(posedge clk_sys) begin
    if (!reset) begin
      if (burst_open && bus_valid && bus_req.write) check(70'h1, 70'h0);
      if (bus_write_done) burst_open = 1'b0;
      if (bus_valid && bus_ready) begin
        if (exp_q.size() == 0) begin
          check(70'h1, 70'h0);
        end else begin
          e = exp_q.pop_front();
          check({bus_req.write, bus_req.last, bus_req.addr, bus_req.be,
                 bus_req.wdata & lmask(e)},
                {e.write, e.last, e.addr, e.be, e.wdata & lmask(e)});
        end
        if (bus_req.write && bus_req.last) burst_open = 1'b1;
      end
    end
  end

  // Watchdog sized well beyond the longest expected run.
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end

  // ==========================================================
  // Main sequence: every merge and lane mode, prompt and slow bus party.
  initial begin
    int m;
    logic [31:0] r;
    logic [31:0] a;
    logic [3:0]  sel;
    reset             = 1'b1;
    merge_full        = 1'b0;
    aligned_lane_mode = 1'b0;
    slow              = 1'b0;
    core_req_valid    = 1'b0;
    core_req          = '0;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    for (m = 0; m < 4; m++) begin
      @(negedge clk_sys);
      merge_full        = m[0];
      aligned_lane_mode = m[1];
      slow              = m[0] ^ m[1];
      mf                = m[0];
      al                = m[1];
      repeat (4) @(negedge clk_sys);
      for (int i = 0; i < 60; i++) begin
        r   = rnd();
        a   = {27'h80, r[8], r[10:9], 2'b00};
        sel = r[19:16];
        core_op((sel == 4'hd) ? cwb_pkg::CWB_BARRIER :
                (sel inside {4'ha, 4'hb, 4'hc}) ? cwb_pkg::CWB_LOAD : cwb_pkg::CWB_STORE,
                sel == 4'h9 || sel == 4'hc, a, pats[r[15:12] % 9], rnd());
      end
      core_op(cwb_pkg::CWB_BARRIER, 1'b0, 32'h0, 4'h0, 32'h0);
      drain_wait();
    end
    end_of_test();
  end
endmodule
